//--- design/mdfs_pkg.sv
package mdfs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS         = 100;
  // Check period of the carrier event after decimation, 100.0 us.
  localparam int CTRL_PERIOD_NS = 100000;
  localparam int CARRIER_DECIM  = 2;
  localparam int CARRIER_CYC    = CTRL_PERIOD_NS / CLK_NS / CARRIER_DECIM;
  localparam int TICK_NS        = 1000000;
  localparam int TICK_CYC       = TICK_NS / CLK_NS;
  localparam int LOCK_MS        = 1000;
  localparam int TICK_MS        = 1;
  localparam int LOCK_TICKS     = LOCK_MS / TICK_MS;

  // ----------------------------------------------------------------
  // Thresholds (mA, mV, degrees C, rpm)
  // ----------------------------------------------------------------
  localparam logic [15:0] OVERCURRENT_THRESHOLD = 16'h424A;
  localparam logic [15:0] BUS_HIGH_THRESHOLD    = 16'h6D60;
  localparam logic [15:0] BUS_LOW_THRESHOLD     = 16'h1F40;
  localparam logic [15:0] BOARD_TEMP_FAULT_LEVEL = 16'h0078;
  localparam logic [15:0] BOARD_TEMP_WARN_SET   = 16'h006E;
  localparam logic [15:0] BOARD_TEMP_WARN_CLEAR = 16'h0069;
  localparam logic [15:0] COIL_TEMP_FAULT_LEVEL = 16'h00B4;
  localparam logic [15:0] COIL_TEMP_WARN_SET    = 16'h00AA;
  localparam logic [15:0] COIL_TEMP_WARN_CLEAR  = 16'h00A5;
  localparam logic [15:0] OVERSPEED_THRESHOLD   = 16'h1388;
  localparam logic [15:0] STALL_THRESHOLD       = 16'h0096;

  // ----------------------------------------------------------------
  // Fault code word
  // ----------------------------------------------------------------
  localparam logic [3:0] BASE_WARN       = 4'h8;
  localparam logic [3:0] BASE_ERR        = 4'hC;
  localparam logic [3:0] MOD_MCU         = 4'h0;
  localparam logic [3:0] MOD_INVERTER    = 4'h1;
  localparam logic [3:0] MOD_VECTOR      = 4'h8;
  localparam logic [3:0] MOD_APPLICATION = 4'h9;
  localparam logic [7:0] FAC_OVERCURRENT = 8'h00;
  localparam logic [7:0] FAC_INIT        = 8'h00;
  localparam logic [7:0] FAC_OVERVOLT    = 8'h10;
  localparam logic [7:0] FAC_UNDERVOLT   = 8'h11;
  localparam logic [7:0] FAC_OVERTEMP    = 8'h20;
  localparam logic [7:0] FAC_OVERSPEED   = 8'h30;
  localparam logic [7:0] FAC_LOCK        = 8'h31;
  localparam logic [7:0] FAC_ILLEGAL     = 8'h80;
  localparam logic [7:0] FAC_UNKNOWN     = 8'hFF;
  localparam int         BASE_LSB        = 12;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_FAULT    = 8'h08;
  localparam int         CTRL_INIT    = 0;
  localparam int         CTRL_RUN     = 1;
  localparam int         ST_ROT_LSB   = 0;
  localparam int         ST_SEQ_LSB   = 3;
  localparam int         ST_WARN_B    = 6;
  localparam int         ST_WARN_C    = 7;
  localparam int         ST_STOP      = 8;
  localparam int         ST_OPEN      = 9;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    sensor_offset_trim_state = 3'h1,
    drive_ready_state        = 3'h2,
    drive_fault_state        = 3'h4
  } mdfs_rot_t;

  typedef enum logic [2:0] {
    system_halted_state  = 3'h1,
    system_running_state = 3'h2,
    system_faulted_state = 3'h4
  } mdfs_seq_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } mdfs_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mdfs_axi_rsp_t;

  // Currents in mA, speed in rpm and temperatures are signed; bus voltage is unsigned.
  typedef struct packed {
    logic [2:0][15:0] phase_ma;
    logic [15:0]      vdc_mv;
    logic [15:0]      board_c;
    logic [15:0]      coil_c;
    logic [15:0]      speed_rpm;
  } mdfs_sense_t;

  typedef struct packed {
    mdfs_rot_t   rot;
    mdfs_seq_t   seq;
    logic [15:0] fault_word;
    logic        warn_board;
    logic        warn_coil;
    logic        run_req;
    logic [15:0] car_cnt;
    logic        decim;
    logic [15:0] ms_cnt;
    logic [9:0]  lock_cnt;
    logic        oc_s1;
    logic        oc_s2;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [7:0]  w_data;
    logic        w_strb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mdfs_state_t;

endpackage

//--- design/mdfs_top.sv
// Operation
// RULE_01 - After init, trim sensor offset, then go to drive ready.
// RULE_02 - Any error sends rotation control to fault; only init leaves it.
// RULE_03 - After init the system sequence sits halted.
// RULE_04 - Sequence requests are evaluated once per 1 ms tick.
// RULE_05 - Running is entered only while rotation control is drive ready.
// RULE_06 - Hardware overcurrent comparator forces PWM off immediately.
// RULE_07 - Phase current beyond +/-16.97 A per carrier check stops output, logs overcurrent.
// RULE_08 - Bus voltage above 28.0 V stops output, logs overvoltage.
// RULE_09 - Bus voltage below 8.0 V stops output, logs undervoltage.
// RULE_10 - Board temperature at or above 120 C stops output, logs overtemperature.
// RULE_11 - Board warning sets at 110 C, clears at 105 C, never stops output.
// RULE_12 - Coil temperature at or above 180 C stops output, logs overtemperature.
// RULE_13 - Coil warning sets at 170 C, clears at 165 C.
// RULE_14 - Speed above 5000 rpm stops output, logs overspeed.
// RULE_15 - Speed below 150 rpm for 1 s while running logs lock.
// RULE_16 - Fault word: base nibble, module nibble, factor byte.
// RULE_17 - Base code 0x8 is warning, 0xC is error.
// RULE_18 - Module 0x0 controller, 0x1 inverter, 0x8 vector, 0x9 application.
// RULE_19 - Factors: overcurrent 0x00, overvoltage 0x10, undervoltage 0x11, init error 0x00.
// RULE_20 - Factors: overtemperature 0x20, overspeed 0x30, lock 0x31.
// RULE_21 - Factors: illegal transition 0x80, unknown 0xFF.
// RULE_22 - Current and voltage checks run every second carrier event, each 100 us.
// RULE_23 - A logged error and the stop persist until init clears the word.
// RULE_24 - While halted or faulted, current control is held open-loop.
`timescale 1ns/10ps
module mdfs_top
  import mdfs_pkg::*;
#(
  parameter int MS_TICK_CYC = mdfs_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  // Register bus
  input  wire mdfs_pkg::mdfs_axi_req_t axi_req,
  output      mdfs_pkg::mdfs_axi_rsp_t axi_rsp,
  // Sensing and estimator inputs
  input  wire mdfs_pkg::mdfs_sense_t   sense,
  input  wire logic                    trim_done,
  input  wire logic                    trim_fail,
  input  wire logic                    oc_trip_n,
  // Drive outputs
  output      logic                    pwm_stop,
  output      logic                    open_loop_mode,
  output      logic                    warn_board,
  output      logic                    warn_coil,
  output      logic [15:0]             fault_code_word
);
  import mdfs_pkg::*;

  localparam logic [15:0] CAR_LAST  = 16'(CARRIER_CYC - 1);
  localparam logic [15:0] MS_LAST   = 16'(MS_TICK_CYC - 1);
  localparam logic [9:0]  LOCK_LAST = 10'(LOCK_TICKS - 1);

  mdfs_state_t st;
  mdfs_state_t nx;
  logic        init;
  logic        car_evt;
  logic        ctl_tick;
  logic        ms_tick;
  logic [2:0]  ph_over;
  logic [15:0] spd_abs;
  logic        oc_sw;
  logic        ov;
  logic        uv;
  logic        bt_hot;
  logic        ct_hot;
  logic        ovsp;
  logic        lock_hit;
  logic        illegal;
  logic        err_hit;
  logic [15:0] err_code;
  logic        warn_new;

  // ----------------------------------------------------------------
  // Bus handshakes and outputs
  // ----------------------------------------------------------------
  always_comb begin
    axi_rsp         = '0;
    axi_rsp.awready = !st.aw_have && !st.bvalid;
    axi_rsp.wready  = !st.w_have && !st.bvalid;
    axi_rsp.bvalid  = st.bvalid;
    axi_rsp.bresp   = st.bresp;
    axi_rsp.arready = !st.rvalid;
    axi_rsp.rvalid  = st.rvalid;
    axi_rsp.rdata   = st.rdata;
    axi_rsp.rresp   = st.rresp;
  end

  // The synchronised comparator bypasses the sequencer so the stop needs no tick.
  assign pwm_stop        = (st.seq != system_running_state) || st.oc_s2; // [RULE_06] [RULE_23]
  assign open_loop_mode  = (st.seq != system_running_state); // [RULE_24]
  assign warn_board      = st.warn_board;
  assign warn_coil       = st.warn_coil;
  assign fault_code_word = st.fault_word;

  // ----------------------------------------------------------------
  // Protection comparators
  // ----------------------------------------------------------------
  for (genvar k = 0; k < 3; k++) begin : g_phase
    assign ph_over[k] = ($signed(sense.phase_ma[k]) > $signed(OVERCURRENT_THRESHOLD)) ||
                        ($signed(sense.phase_ma[k]) < -$signed(OVERCURRENT_THRESHOLD)); // [RULE_07]
  end

  assign car_evt  = (st.car_cnt == CAR_LAST);
  assign ctl_tick = car_evt && st.decim; // [RULE_22]
  assign ms_tick  = (st.ms_cnt == MS_LAST);
  assign spd_abs  = sense.speed_rpm[15] ? 16'(-sense.speed_rpm) : sense.speed_rpm;
  assign oc_sw    = ctl_tick && (|ph_over); // [RULE_07]
  assign ov       = ctl_tick && (sense.vdc_mv > BUS_HIGH_THRESHOLD); // [RULE_08]
  assign uv       = ctl_tick && (sense.vdc_mv < BUS_LOW_THRESHOLD); // [RULE_09]
  assign bt_hot   = ms_tick && ($signed(sense.board_c) >= $signed(BOARD_TEMP_FAULT_LEVEL)); // [RULE_10]
  assign ct_hot   = ms_tick && ($signed(sense.coil_c) >= $signed(COIL_TEMP_FAULT_LEVEL)); // [RULE_12]
  assign ovsp     = ms_tick && (spd_abs > OVERSPEED_THRESHOLD); // [RULE_14]
  assign lock_hit = ms_tick && (st.seq == system_running_state) &&
                    (spd_abs < STALL_THRESHOLD) && (st.lock_cnt == LOCK_LAST); // [RULE_15]
  assign illegal  = !(st.rot inside {sensor_offset_trim_state, drive_ready_state, drive_fault_state}) ||
                    !(st.seq inside {system_halted_state, system_running_state, system_faulted_state});

  // ----------------------------------------------------------------
  // Fault code selection, highest priority first
  // ----------------------------------------------------------------
  always_comb begin
    err_hit = 1'b1;
    if (st.oc_s2 || oc_sw) begin
      err_code = {BASE_ERR, MOD_INVERTER, FAC_OVERCURRENT}; // [RULE_19]
    end else if (ov) begin
      err_code = {BASE_ERR, MOD_INVERTER, FAC_OVERVOLT}; // [RULE_19]
    end else if (uv) begin
      err_code = {BASE_ERR, MOD_INVERTER, FAC_UNDERVOLT}; // [RULE_19]
    end else if (bt_hot || ct_hot) begin
      err_code = {BASE_ERR, MOD_APPLICATION, FAC_OVERTEMP}; // [RULE_20]
    end else if (ovsp) begin
      err_code = {BASE_ERR, MOD_VECTOR, FAC_OVERSPEED}; // [RULE_20]
    end else if (lock_hit) begin
      err_code = {BASE_ERR, MOD_VECTOR, FAC_LOCK}; // [RULE_20]
    end else if (illegal) begin
      err_code = {BASE_ERR, MOD_VECTOR, FAC_ILLEGAL}; // [RULE_21]
    end else if (trim_fail && st.rot == sensor_offset_trim_state) begin
      err_code = {BASE_ERR, MOD_MCU, FAC_INIT}; // [RULE_16] [RULE_17] [RULE_18] [RULE_19]
    end else begin
      err_hit  = 1'b0;
      err_code = {BASE_ERR, MOD_MCU, FAC_UNKNOWN}; // [RULE_21]
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nx       = st;
    init     = 1'b0;
    warn_new = 1'b0;
    nx.oc_s1 = !oc_trip_n;
    nx.oc_s2 = st.oc_s1;

    // Write channel: address and data are taken in either order.
    if (axi_req.awvalid && axi_rsp.awready) begin
      nx.aw_have = 1'b1;
      nx.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      nx.w_have  = 1'b1;
      nx.w_data  = axi_req.wdata[7:0];
      nx.w_strb0 = axi_req.wstrb[0];
    end
    if (st.aw_have && st.w_have) begin
      nx.aw_have = 1'b0;
      nx.w_have  = 1'b0;
      nx.bvalid  = 1'b1;
      nx.bresp   = RESP_OKAY;
      if (st.aw_addr == REG_CTRL) begin
        if (st.w_strb0) begin
          nx.run_req = st.w_data[CTRL_RUN];
          init       = st.w_data[CTRL_INIT];
        end
      end else if (st.aw_addr != REG_STATUS && st.aw_addr != REG_FAULT) begin
        nx.bresp = RESP_SLVERR;
      end
    end
    if (st.bvalid && axi_req.bready) begin
      nx.bvalid = 1'b0;
    end

    // Read channel.
    if (axi_req.arvalid && axi_rsp.arready) begin
      nx.rvalid = 1'b1;
      nx.rresp  = RESP_OKAY;
      nx.rdata  = '0;
      if (axi_req.araddr == REG_CTRL) begin
        nx.rdata[CTRL_RUN] = st.run_req;
      end else if (axi_req.araddr == REG_STATUS) begin
        nx.rdata[ST_ROT_LSB +: 3] = st.rot;
        nx.rdata[ST_SEQ_LSB +: 3] = st.seq;
        nx.rdata[ST_WARN_B]       = st.warn_board;
        nx.rdata[ST_WARN_C]       = st.warn_coil;
        nx.rdata[ST_STOP]         = pwm_stop;
        nx.rdata[ST_OPEN]         = open_loop_mode;
      end else if (axi_req.araddr == REG_FAULT) begin
        nx.rdata[15:0] = st.fault_word;
      end else begin
        nx.rresp = RESP_SLVERR;
      end
    end else if (st.rvalid && axi_req.rready) begin
      nx.rvalid = 1'b0;
    end

    // Carrier decimation and the 1 ms tick.
    nx.car_cnt = car_evt ? '0 : 16'(st.car_cnt + 16'h0001);
    if (car_evt) begin
      nx.decim = !st.decim; // [RULE_22]
    end
    nx.ms_cnt = ms_tick ? '0 : 16'(st.ms_cnt + 16'h0001);

    // Lock timer counts consecutive slow ticks while running.
    if (st.seq != system_running_state || spd_abs >= STALL_THRESHOLD) begin
      nx.lock_cnt = '0;
    end else if (ms_tick && st.lock_cnt != LOCK_LAST) begin
      nx.lock_cnt = 10'(st.lock_cnt + 10'h001); // [RULE_15]
    end

    // Temperature warnings with hysteresis, updated on the tick.
    if (ms_tick) begin
      if ($signed(sense.board_c) >= $signed(BOARD_TEMP_WARN_SET)) begin
        nx.warn_board = 1'b1; // [RULE_11]
      end else if ($signed(sense.board_c) <= $signed(BOARD_TEMP_WARN_CLEAR)) begin
        nx.warn_board = 1'b0; // [RULE_11]
      end
      if ($signed(sense.coil_c) >= $signed(COIL_TEMP_WARN_SET)) begin
        nx.warn_coil = 1'b1; // [RULE_13]
      end else if ($signed(sense.coil_c) <= $signed(COIL_TEMP_WARN_CLEAR)) begin
        nx.warn_coil = 1'b0; // [RULE_13]
      end
      warn_new = (nx.warn_board && !st.warn_board) || (nx.warn_coil && !st.warn_coil);
    end

    if (init) begin
      nx.rot        = sensor_offset_trim_state; // [RULE_01]
      nx.seq        = system_halted_state; // [RULE_03]
      nx.fault_word = '0; // [RULE_23]
      nx.lock_cnt   = '0;
      nx.warn_board = 1'b0;
      nx.warn_coil  = 1'b0;
    end else if (err_hit) begin
      nx.rot = drive_fault_state; // [RULE_02]
      nx.seq = system_faulted_state;
      if (st.fault_word[BASE_LSB +: 4] != BASE_ERR) begin
        nx.fault_word = err_code; // [RULE_23]
      end
    end else begin
      if (st.rot == sensor_offset_trim_state && trim_done) begin
        nx.rot = drive_ready_state; // [RULE_01]
      end
      if (ms_tick) begin // [RULE_04]
        if (st.seq == system_halted_state && st.run_req && st.rot == drive_ready_state) begin
          nx.seq = system_running_state; // [RULE_05]
        end else if (st.seq == system_running_state && !st.run_req) begin
          nx.seq = system_halted_state;
        end
      end
      if (warn_new && st.fault_word == '0) begin
        nx.fault_word = {BASE_WARN, MOD_APPLICATION, FAC_OVERTEMP}; // [RULE_17]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st     <= '0;
      st.rot <= sensor_offset_trim_state;
      st.seq <= system_halted_state;
    end else begin
      st <= nx;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_init_req;
    init;
  endsequence

  sequence s_init_done;
    st.rot == sensor_offset_trim_state && st.seq == system_halted_state && st.fault_word == '0;
  endsequence

  a_init_clears: assert property (s_init_req |=> s_init_done) // [RULE_03]
    else $error("Init did not restore halted trim state with empty word.");

  a_trim_ready: assert property (st.rot == sensor_offset_trim_state && trim_done && !err_hit && !init
                                 |=> st.rot == drive_ready_state) // [RULE_01]
    else $error("Trim completion did not reach drive ready.");

  a_fault_sticky: assert property (st.rot == drive_fault_state && !init |=> st.rot == drive_fault_state) // [RULE_02]
    else $error("Drive fault left without init.");

  a_run_on_tick: assert property ($rose(st.seq == system_running_state) |-> $past(ms_tick)) // [RULE_04]
    else $error("Running entered outside a 1 ms tick.");

  a_run_ready: assert property (st.seq == system_running_state |-> st.rot == drive_ready_state) // [RULE_05]
    else $error("Running while rotation control not ready.");

  a_hw_stop: assert property (!oc_trip_n ##1 !oc_trip_n |=> pwm_stop) // [RULE_06]
    else $error("Comparator trip did not stop PWM.");

  a_oc_logged: assert property (oc_sw && !init && st.fault_word[15:12] != BASE_ERR
                                |=> st.fault_word == {BASE_ERR, MOD_INVERTER, FAC_OVERCURRENT}
                                    && pwm_stop) // [RULE_07]
    else $error("Software overcurrent not logged.");

  a_ov_logged: assert property (ov && !oc_sw && !st.oc_s2 && !init && st.fault_word[15:12] != BASE_ERR
                                |=> st.fault_word == {BASE_ERR, MOD_INVERTER, FAC_OVERVOLT}) // [RULE_08]
    else $error("Overvoltage not logged.");

  a_check_rate: assert property (ctl_tick |=> !ctl_tick [*8]) // [RULE_22]
    else $error("Carrier checks closer than decimated period.");

  a_word_holds: assert property (st.fault_word[15:12] == BASE_ERR && !init |=> $stable(st.fault_word)) // [RULE_23]
    else $error("Logged error changed without init.");

  a_board_warn: assert property ($rose(st.warn_board) |-> $past(ms_tick) &&
                                 $signed($past(sense.board_c)) >= $signed(BOARD_TEMP_WARN_SET)) // [RULE_11]
    else $error("Board warning set below its threshold.");

  a_open_loop: assert property (st.seq != system_running_state |-> open_loop_mode) // [RULE_24]
    else $error("Open loop not held while stopped.");

endmodule

//--- bench/mdfs_drive_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Inverter, motor and sensing front end
// ----------------------------------------------------------------
module mdfs_drive_model
  import mdfs_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  arst_n,
  // Scenario controls
  input  wire mdfs_pkg::mdfs_sense_t cmd,
  input  wire logic                  trip_req,
  input  wire logic                  trim_ok,
  // Drive state
  input  wire logic                  pwm_stop,
  // Towards the block
  output      mdfs_pkg::mdfs_sense_t sense,
  output      logic                  trim_done,
  output      logic                  trim_fail,
  output      logic                  oc_trip_n
);
  // A stopped bridge gives no torque, so the estimator reports standstill.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sense     <= '0;
      trim_done <= 1'b0;
      trim_fail <= 1'b0;
      oc_trip_n <= 1'b1;
    end else begin
      sense           <= cmd;
      sense.speed_rpm <= pwm_stop ? 16'h0000 : cmd.speed_rpm;
      trim_done       <= trim_ok;
      trim_fail       <= 1'b0;
      oc_trip_n       <= !trip_req;
    end
  end
endmodule

//--- bench/test_mdfs_top.sv
`timescale 1ns/10ps
module test_mdfs_top
  import mdfs_pkg::*;
;
  logic          sys_clk  = 1'b0;
  logic          arst_n   = 1'b0;
  mdfs_axi_req_t req      = '0;
  mdfs_axi_rsp_t rsp;
  mdfs_sense_t   cmd;
  mdfs_sense_t   sense;
  logic          trip_req = 1'b0;
  logic          trim_ok  = 1'b0;
  logic          trim_done, trim_fail, oc_trip_n, pwm_stop, open_loop_mode, warn_board, warn_coil;
  logic [15:0]   fault_code_word;
  logic [33:0]   expq[$];
  logic [31:0]   rs       = 32'hb314_6ce3;
  int            mismatches  = 0;
  int            check_count = 0;
  int            cycles      = 0;
  logic [15:0]   fexp[9]  = '{16'hC100, 16'hC100, 16'hC110, 16'hC111, 16'hC920, 16'hC920, 16'hC830, 16'hC831,
                              16'hC100};
  logic [15:0]   wt[4]    = '{16'h006D, 16'h006E, 16'h006A, 16'h0069};
  logic [3:0]    we       = 4'b0110;

  always #50 sys_clk = ~sys_clk;

  mdfs_top #(.MS_TICK_CYC(20)) mdfs_top_i (.sys_clk(sys_clk), .arst_n(arst_n), .axi_req(req), .axi_rsp(rsp),
    .sense(sense), .trim_done(trim_done), .trim_fail(trim_fail), .oc_trip_n(oc_trip_n), .pwm_stop(pwm_stop),
    .open_loop_mode(open_loop_mode), .warn_board(warn_board), .warn_coil(warn_coil),
    .fault_code_word(fault_code_word));
  mdfs_drive_model mdfs_drive_model_i (.sys_clk(sys_clk), .arst_n(arst_n), .cmd(cmd), .trip_req(trip_req),
    .trim_ok(trim_ok), .pwm_stop(pwm_stop), .sense(sense), .trim_done(trim_done), .trim_fail(trim_fail),
    .oc_trip_n(oc_trip_n));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic end_sim();
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_pin(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_bus(input string n, input logic [33:0] e, input logic [33:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw;
    logic wd;
    logic bv;
    @(posedge sys_clk);
    expq.push_back({r, 32'h0000_0000});
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    // Readies are sampled mid-cycle so the handshake edge is never raced.
    do begin
      @(negedge sys_clk);
      aw = rsp.awready;
      wd = rsp.wready;
      bv = rsp.bvalid;
      @(posedge sys_clk);
      if (aw) req.awvalid <= 1'b0;
      if (wd) req.wvalid <= 1'b0;
    end while (!bv);
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ar;
    logic rv;
    @(posedge sys_clk);
    expq.push_back({r, d});
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(negedge sys_clk);
      ar = rsp.arready;
      rv = rsp.rvalid;
      @(posedge sys_clk);
      if (ar) req.arvalid <= 1'b0;
    end while (!rv);
    req.rready <= 1'b0;
  endtask
  task automatic nominal();
    cmd      <= {{16'h424A, 16'hBDB6, 16'h0000}, 16'h6D60, 16'h0019, 16'h0019, 16'h07D0};
    trip_req <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Response monitor and watchdog
  // ----------------------------------------------------------------
  // Responses are compared mid-cycle, in the cycle before the accepting edge.
  always @(negedge sys_clk) begin
    cycles++;
    if ((rsp.rvalid && req.rready) || (rsp.bvalid && req.bready))
      chk_bus(rsp.rvalid ? "rd" : "wr", expq.pop_front(), rsp.rvalid ? {rsp.rresp, rsp.rdata} : {rsp.bresp, 32'h0});
    if (cycles == 80000) begin
      mismatches++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    nominal();
    cyc(10);
    arst_n <= 1'b1;
    wr(REG_CTRL, 32'h0000_0002, RESP_OKAY);
    cyc(60);
    chk_pin("pwm_stop", 16'h0001, {15'h0, pwm_stop});
    rd(REG_STATUS, 32'h0000_0309, RESP_OKAY);
    trim_ok <= 1'b1;
    cyc(60);
    rd(REG_STATUS, 32'h0000_0012, RESP_OKAY);
    chk_pin("open_loop", 16'h0000, {15'h0, open_loop_mode});
    cyc(1100);
    chk_pin("pwm_stop", 16'h0000, {15'h0, pwm_stop});
    for (int i = 0; i < 20; i++) begin
      rs = xs(rs);
      cmd.phase_ma[0] <= 16'(rs % 32'h0000_8495) - 16'h424A;
      rs = xs(rs);
      cmd.vdc_mv <= 16'h1F40 + 16'(rs % 32'h0000_4E21);
      rs = xs(rs);
      cmd.speed_rpm <= 16'h03E8 + 16'(rs % 32'h0000_0BB8);
      cyc(300);
      chk_pin("pwm_stop", 16'h0000, {15'h0, pwm_stop});
    end
    for (int s = 0; s < 2; s++) for (int j = 0; j < 4; j++) begin
      if (s == 0) cmd.board_c <= wt[j];
      else cmd.coil_c <= wt[j] + 16'h003C;
      cyc(60);
      chk_pin("warn", {15'h0, we[j]}, {15'h0, s ? warn_coil : warn_board});
    end
    chk_pin("pwm_stop", 16'h0000, {15'h0, pwm_stop});
    rd(REG_FAULT, 32'h0000_8920, RESP_OKAY);
    for (int k = 0; k < 9; k++) begin
      nominal();
      wr(REG_CTRL, 32'h0000_0003, RESP_OKAY);
      cyc(60);
      rd(REG_FAULT, 32'h0000_0000, RESP_OKAY);
      case (k)
        0: cmd.phase_ma[1] <= 16'h424B;
        1: cmd.phase_ma[2] <= 16'hBDB5;
        2: cmd.vdc_mv <= 16'h6D61;
        3: cmd.vdc_mv <= 16'h1F3F;
        4: cmd.board_c <= 16'h0078;
        5: cmd.coil_c <= 16'h00B4;
        6: cmd.speed_rpm <= 16'h1389;
        7: cmd.speed_rpm <= 16'h0064;
        default: trip_req <= 1'b1;
      endcase
      if (k == 7) begin
        cyc(19500);
        chk_pin("lock_early", 16'h0000, {15'h0, pwm_stop});
      end
      cyc(k == 7 ? 800 : (k == 8 ? 5 : 1100));
      chk_pin("pwm_stop", 16'h0001, {15'h0, pwm_stop});
      nominal();
      cyc(1100);
      chk_pin("pwm_stop_held", 16'h0001, {15'h0, pwm_stop});
      chk_pin("fault_word", fexp[k], fault_code_word);
    end
    rd(REG_STATUS, 32'h0000_0324, RESP_OKAY);
    wr(REG_FAULT, 32'h0000_0000, RESP_OKAY);
    rd(REG_FAULT, 32'h0000_C100, RESP_OKAY);
    wr(8'h40, 32'h0000_0001, RESP_SLVERR);
    rd(8'h40, 32'h0000_0000, RESP_SLVERR);
    end_sim();
  end
endmodule
